// File: fpd_consts.svh
// Purpose: Offsets, field positions, reset values and timing counts for the fan PWM drive block.
// Assumes: 10 MHz system clock; registers reached through the device's internal register port.
// Notes: Definitions only.
// Overview of operation
// - Low-rate mode: three-bit rate_select picks 11.0 to 88.2 Hz, reset code 100.
// - Bit 3 of a fan's drive-rate register puts only that fan in high-rate mode.
// - High-rate mode fixes the period at 22.5 kHz regardless of rate_select.
// - High-rate mode forces that fan's continuous tach flag with no software write.
// - Automatic mode varies duty from temperature with no host involvement.
// - behaviour_select bits 7:5 of drive config choose operation; 111 is manual.
// - In manual mode the written current-duty value drives the output.
// - Current duty is eight bits, 0 to 100 percent, about 0.39 percent per code.
// - Current-duty registers reset to 0xff, full drive.
// - Reading current duty returns the duty actually output, in every mode.
// - Manual mode above overtemp_limit forces configured maximum or full duty.
// - Automatic duty ramps linearly from minimum to full across the temperature span.
// - Each temperature channel has its own start temperature and span.
// - Each fan has own minimum duty and ramp rate.
// - Continuous tach flag makes tach measurement run free of the PWM drive.
// - behaviour_select 011 runs full speed, 100 disables; 100 is the reset value.
// - Above start temperature the automatic fan starts at its minimum duty.
`ifndef FPD_CONSTS_SVH
`define FPD_CONSTS_SVH

// Register offsets
`define FPD_OFS_DUTY1 8'h30
`define FPD_OFS_DUTY2 8'h31
`define FPD_OFS_DUTY3 8'h32
`define FPD_OFS_CFG1 8'h5c
`define FPD_OFS_CFG2 8'h5d
`define FPD_OFS_CFG3 8'h5e
`define FPD_OFS_RATE1 8'h5f
`define FPD_OFS_RATE2 8'h60
`define FPD_OFS_RATE3 8'h61

// Field positions
`define FPD_CFG_BHV_HI 7
`define FPD_CFG_BHV_LO 5
`define FPD_CFG_INV_BIT 4
`define FPD_RATE_HF_BIT 3
`define FPD_RATE_SEL_HI 2

// Reset values and duty levels
`define FPD_DUTY_RST 8'hff
`define FPD_CFG_RST 8'h82
`define FPD_RATE_RST 8'h04
`define FPD_DUTY_FULL 8'hff
`define FPD_DUTY_OFF 8'h00

// behaviour_select codes
`define FPD_BHV_REM1 3'h0
`define FPD_BHV_LOCAL 3'h1
`define FPD_BHV_REM2 3'h2
`define FPD_BHV_FULL 3'h3
`define FPD_BHV_OFF 3'h4
`define FPD_BHV_LOC_REM2 3'h5
`define FPD_BHV_ALL 3'h6
`define FPD_BHV_MANUAL 3'h7

// Timing: low rates in tenths of a hertz, high rate in hertz, cycle counts derived from the clock
`define FPD_CLK_HZ 10000000
`define FPD_LF_DHZ0 110
`define FPD_LF_DHZ1 147
`define FPD_LF_DHZ2 221
`define FPD_LF_DHZ3 294
`define FPD_LF_DHZ4 353
`define FPD_LF_DHZ5 441
`define FPD_LF_DHZ6 588
`define FPD_LF_DHZ7 882
`define FPD_LF_CYC(d) ((`FPD_CLK_HZ * 10) / (d))
`define FPD_HF_HZ 22500
`define FPD_HF_CYC (`FPD_CLK_HZ / `FPD_HF_HZ)

`endif

// File: fpd_pkg.sv
// Purpose: Shared types of the fan PWM drive block.
// Assumes: Nothing beyond the constants header.
// Notes: Types only.
package fpd_pkg;
    typedef logic [7:0] fpd_duty_t;
    typedef logic [19:0] fpd_cyc_t;
    typedef logic [2:0][7:0] fpd_trio_t;
endpackage : fpd_pkg

// File: fpd_chan_if.sv
// Purpose: Carries one fan channel between the control core and its PWM generator.
// Assumes: Single clock domain.
// Notes: Core drives requests, generator reports the applied period start.
`timescale 1ns/10ps
`default_nettype none
interface fpd_chan_if;
    import fpd_pkg::*;
    fpd_duty_t duty;
    fpd_cyc_t period;
    logic invert;
    logic period_start;
    logic pwm_out;
    modport core (output duty, output period, output invert, input period_start, input pwm_out);
    modport gen (input duty, input period, input invert, output period_start, output pwm_out);
endinterface : fpd_chan_if
`default_nettype wire

// File: fpd_pwm_gen.sv
// Purpose: One PWM channel: period counter and duty compare.
// Assumes: Period of at least one cycle; requests stable from the core.
// Notes: Duty, period and polarity are sampled only at the period wrap.
`timescale 1ns/10ps
`default_nettype none
`include "fpd_consts.svh"
module fpd_pwm_gen (
    // Clock and control
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    // Channel
    fpd_chan_if.gen ch
);
    import fpd_pkg::*;

    fpd_cyc_t cnt_ff;
    fpd_cyc_t per_ff;
    fpd_duty_t duty_ff;
    logic inv_ff;
    logic out_ff;
    logic wrap;
    logic [27:0] lhs;
    logic [27:0] rhs;

    assign wrap = (cnt_ff >= per_ff - 20'd1);
    assign ch.period_start = ce & wrap;

    // Settings latched at the wrap so no pulse is shortened mid-period
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cnt_ff <= 20'h0;
            per_ff <= 20'h1;
            duty_ff <= `FPD_DUTY_RST;
            inv_ff <= 1'b0;
        end else if (ce) begin
            if (wrap) begin
                cnt_ff <= 20'h0;
                per_ff <= (ch.period == 20'h0) ? 20'h1 : ch.period;
                duty_ff <= ch.duty;
                inv_ff <= ch.invert;
            end else begin
                cnt_ff <= cnt_ff + 20'h1;
            end
        end
    end

    // Active while cnt*255 < duty*period, so 0xff never drops
    assign lhs = 28'(cnt_ff) * 28'd255;
    assign rhs = 28'(duty_ff) * 28'(per_ff);

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            out_ff <= 1'b1;
        end else if (ce) begin
            out_ff <= (lhs < rhs) ^ inv_ff;
        end
    end

    assign ch.pwm_out = out_ff;
endmodule : fpd_pwm_gen
`default_nettype wire

// File: fpd_auto_calc.sv
// Purpose: Automatic duty from one temperature channel for one fan.
// Assumes: Unsigned temperatures in degrees; span of zero treated as a step.
// Notes: Pure combinational; the core registers the result.
`timescale 1ns/10ps
`default_nettype none
`include "fpd_consts.svh"
module fpd_auto_calc (
    // Temperature channel calibration
    input wire logic [7:0] temp,
    input wire logic [7:0] start_temp,
    input wire logic [7:0] span,
    // Fan setting
    input wire logic [7:0] min_duty,
    // Result
    output logic [7:0] duty
);
    import fpd_pkg::*;

    logic [7:0] over;
    logic [15:0] scaled;
    logic [8:0] sum;

    // Linear ramp from minimum to full over the span
    always_comb begin
        over = temp - start_temp;
        scaled = 16'(8'(`FPD_DUTY_FULL - min_duty)) * 16'(over);
        sum = 9'h0;
        if (temp <= start_temp) begin
            duty = `FPD_DUTY_OFF;
        end else if (span == 8'h0 || over >= span) begin
            duty = `FPD_DUTY_FULL;
        end else begin
            sum = 9'(min_duty) + 9'(scaled / 16'(span));
            duty = (sum > 9'h0ff) ? `FPD_DUTY_FULL : sum[7:0];
        end
    end
endmodule : fpd_auto_calc
`default_nettype wire

// File: fpd_top.sv
// Purpose: Three-channel fan PWM drive with manual, automatic, full and off behaviours.
// Assumes: Register port fed by the device's serial management decoder on SYS_CLK;
//          temperatures and calibration come from same-clock logic.
// Notes: Current-duty reads return the duty applied to the generator.
`timescale 1ns/10ps
`default_nettype none
`include "fpd_consts.svh"
module fpd_top #(
    parameter logic [19:0] LF_CYC [0:7] = '{
        20'(`FPD_LF_CYC(`FPD_LF_DHZ0)), 20'(`FPD_LF_CYC(`FPD_LF_DHZ1)),
        20'(`FPD_LF_CYC(`FPD_LF_DHZ2)), 20'(`FPD_LF_CYC(`FPD_LF_DHZ3)),
        20'(`FPD_LF_CYC(`FPD_LF_DHZ4)), 20'(`FPD_LF_CYC(`FPD_LF_DHZ5)),
        20'(`FPD_LF_CYC(`FPD_LF_DHZ6)), 20'(`FPD_LF_CYC(`FPD_LF_DHZ7))}
) (
    // Clock, reset, enable
    input wire logic SYS_CLK,
    input wire logic RSTN,
    input wire logic CE,
    // Register port
    input wire logic [7:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    input wire logic REG_WR,
    output logic [7:0] REG_RDATA,
    // Temperatures: 0 remote 1, 1 local, 2 remote 2
    input wire fpd_pkg::fpd_trio_t TEMP_IN,
    input wire fpd_pkg::fpd_trio_t START_TEMP,
    input wire fpd_pkg::fpd_trio_t TEMP_SPAN,
    input wire logic [7:0] OVERTEMP_LIMIT,
    // Per-fan settings
    input wire fpd_pkg::fpd_trio_t MIN_DUTY,
    input wire fpd_pkg::fpd_trio_t MAX_DUTY,
    input wire fpd_pkg::fpd_trio_t RAMP_STEP,
    input wire logic [2:0] OT_TO_MAX,
    input wire logic [2:0] DC_FAN,
    // Fan outputs
    output logic [2:0] PWM_OUT,
    output logic [2:0] TACH_CONT
);
    import fpd_pkg::*;

    fpd_duty_t manual_ff [3];
    fpd_duty_t applied_ff [3];
    logic [7:0] cfg_ff [3];
    logic [7:0] rate_ff [3];
    logic [7:0] rdata_ff;
    logic overtemp;
    fpd_chan_if chan [3] ();

    // Overtemperature seen on any channel
    assign overtemp = (TEMP_IN[0] > OVERTEMP_LIMIT) | (TEMP_IN[1] > OVERTEMP_LIMIT) |
                      (TEMP_IN[2] > OVERTEMP_LIMIT);

    genvar f;
    genvar t;
    generate
        for (f = 0; f < 3; f++) begin : g_fan
            fpd_duty_t auto_duty [3];
            fpd_duty_t target;
            fpd_duty_t nxt_applied;
            logic [2:0] bhv;
            logic hf;
            logic is_auto;
            logic [8:0] up;

            // Per-temperature calibration, same fan minimum
            for (t = 0; t < 3; t++) begin : g_tmp
                fpd_auto_calc u_calc (
                    .temp(TEMP_IN[t]),
                    .start_temp(START_TEMP[t]),
                    .span(TEMP_SPAN[t]),
                    .min_duty(MIN_DUTY[f]),
                    .duty(auto_duty[t])
                );
            end

            assign bhv = cfg_ff[f][`FPD_CFG_BHV_HI:`FPD_CFG_BHV_LO];
            assign hf = rate_ff[f][`FPD_RATE_HF_BIT];

            // Register writes for this fan
            always_ff @(posedge SYS_CLK) begin
                if (!RSTN) begin
                    cfg_ff[f] <= `FPD_CFG_RST;
                    rate_ff[f] <= `FPD_RATE_RST;
                end else if (CE && REG_WR) begin
                    if (REG_ADDR == `FPD_OFS_CFG1 + 8'(f)) begin
                        cfg_ff[f] <= REG_WDATA;
                    end
                    if (REG_ADDR == `FPD_OFS_RATE1 + 8'(f)) begin
                        rate_ff[f] <= REG_WDATA;
                    end
                end
            end

            // Software duty; writes only land in manual mode
            always_ff @(posedge SYS_CLK) begin
                if (!RSTN) begin
                    manual_ff[f] <= `FPD_DUTY_RST;
                end else if (CE && REG_WR && bhv == `FPD_BHV_MANUAL &&
                             REG_ADDR == `FPD_OFS_DUTY1 + 8'(f)) begin
                    manual_ff[f] <= REG_WDATA;
                end
            end

            // Behaviour selection
            always_comb begin
                is_auto = 1'b1;
                case (bhv)
                    `FPD_BHV_REM1: target = auto_duty[0];
                    `FPD_BHV_LOCAL: target = auto_duty[1];
                    `FPD_BHV_REM2: target = auto_duty[2];
                    `FPD_BHV_LOC_REM2: target = (auto_duty[1] > auto_duty[2]) ? auto_duty[1] : auto_duty[2];
                    `FPD_BHV_ALL: begin
                        target = (auto_duty[1] > auto_duty[2]) ? auto_duty[1] : auto_duty[2];
                        target = (auto_duty[0] > target) ? auto_duty[0] : target;
                    end
                    `FPD_BHV_FULL: begin
                        is_auto = 1'b0;
                        target = `FPD_DUTY_FULL;
                    end
                    `FPD_BHV_OFF: begin
                        is_auto = 1'b0;
                        target = `FPD_DUTY_OFF;
                    end
                    `FPD_BHV_MANUAL: begin
                        is_auto = 1'b0;
                        if (overtemp) begin
                            target = OT_TO_MAX[f] ? MAX_DUTY[f] : `FPD_DUTY_FULL;
                        end else begin
                            target = manual_ff[f];
                        end
                    end
                    default: begin
                        is_auto = 1'b0;
                        target = `FPD_DUTY_FULL;
                    end
                endcase
            end

            // Ramp limit in automatic mode; zero step means jump directly
            always_comb begin
                up = 9'(applied_ff[f]) + 9'(RAMP_STEP[f]);
                nxt_applied = target;
                if (is_auto && RAMP_STEP[f] != 8'h0) begin
                    if (target > applied_ff[f]) begin
                        nxt_applied = (up > 9'(target)) ? target : up[7:0];
                    end else if (target < applied_ff[f]) begin
                        nxt_applied = (applied_ff[f] - target > RAMP_STEP[f]) ?
                                      applied_ff[f] - RAMP_STEP[f] : target;
                    end
                end
            end

            // Duty follows the generator period so readback matches the pin
            always_ff @(posedge SYS_CLK) begin
                if (!RSTN) begin
                    applied_ff[f] <= `FPD_DUTY_RST;
                end else if (CE && chan[f].period_start) begin
                    applied_ff[f] <= nxt_applied;
                end
            end

            // Generator requests; the generator samples them at its wrap
            assign chan[f].duty = nxt_applied;
            assign chan[f].period = hf ? 20'(`FPD_HF_CYC) :
                                    LF_CYC[rate_ff[f][`FPD_RATE_SEL_HI:0]];
            assign chan[f].invert = cfg_ff[f][`FPD_CFG_INV_BIT];

            fpd_pwm_gen u_gen (
                .clk(SYS_CLK),
                .rst_n(RSTN),
                .ce(CE),
                .ch(chan[f])
            );

            assign PWM_OUT[f] = chan[f].pwm_out;
            assign TACH_CONT[f] = DC_FAN[f] | hf;
        end
    endgenerate

    // Registered read data; unmapped offsets read zero
    always_ff @(posedge SYS_CLK) begin
        if (!RSTN) begin
            rdata_ff <= 8'h00;
        end else if (CE) begin
            case (REG_ADDR)
                `FPD_OFS_DUTY1: rdata_ff <= applied_ff[0];
                `FPD_OFS_DUTY2: rdata_ff <= applied_ff[1];
                `FPD_OFS_DUTY3: rdata_ff <= applied_ff[2];
                `FPD_OFS_CFG1: rdata_ff <= cfg_ff[0];
                `FPD_OFS_CFG2: rdata_ff <= cfg_ff[1];
                `FPD_OFS_CFG3: rdata_ff <= cfg_ff[2];
                `FPD_OFS_RATE1: rdata_ff <= rate_ff[0];
                `FPD_OFS_RATE2: rdata_ff <= rate_ff[1];
                `FPD_OFS_RATE3: rdata_ff <= rate_ff[2];
                default: rdata_ff <= 8'h00;
            endcase
        end
    end

    assign REG_RDATA = rdata_ff;
endmodule : fpd_top
`default_nettype wire

// File: fpd_top_sva.sv
// Purpose: Port-level checks for the fan PWM drive block.
// Assumes: One clock; fan 1 settings shadowed from register writes.
// Notes: Settle window spans two of the longest periods.
`timescale 1ns/10ps
`default_nettype none
`include "fpd_consts.svh"
module fpd_top_chk #(
    parameter logic [19:0] LF_CYC [0:7] = '{default: 20'h1}
) (
    // Clock, reset, enable
    input wire logic SYS_CLK,
    input wire logic RSTN,
    input wire logic CE,
    // Register port
    input wire logic [7:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic [7:0] REG_RDATA,
    // Fan side
    input wire logic [2:0] DC_FAN,
    input wire logic [2:0] PWM_OUT,
    input wire logic [2:0] TACH_CONT
);
    // Longest period twice, so a mode change has surely landed
    function automatic int settle_f();
        int m = 0;
        foreach (LF_CYC[i]) m = (int'(LF_CYC[i]) > m) ? int'(LF_CYC[i]) : m;
        return 2 * m + 2 * `FPD_HF_CYC + 4;
    endfunction : settle_f
    localparam int SETTLE = settle_f();
    logic [2:0] bhv0_ff;
    logic inv0_ff;
    logic hf0_ff;
    int quiet_ff;
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (!RSTN);
    // Shadow of fan 1 behaviour, polarity and high-rate bit
    always_ff @(posedge SYS_CLK) begin
        if (!RSTN) begin
            bhv0_ff <= 3'h4;
            inv0_ff <= 1'b0;
            hf0_ff <= 1'b0;
        end else if (CE && REG_WR && REG_ADDR == 8'h5c) begin
            bhv0_ff <= REG_WDATA[7:5];
            inv0_ff <= REG_WDATA[4];
        end else if (CE && REG_WR && REG_ADDR == 8'h5f) begin
            hf0_ff <= REG_WDATA[3];
        end
    end
    // Enabled cycles since the last write, saturating
    always_ff @(posedge SYS_CLK) begin
        if (!RSTN || (CE && REG_WR)) begin
            quiet_ff <= 0;
        end else if (CE && quiet_ff < SETTLE) begin
            quiet_ff <= quiet_ff + 1;
        end
    end
    tach_follow_a: assert property (TACH_CONT[0] == (DC_FAN[0] | hf0_ff))
        else $error("tach flag wrong");
    cfg_readback_a: assert property ((CE && REG_WR && REG_ADDR inside {[8'h5c:8'h61]})
        ##1 (CE && !REG_WR && $stable(REG_ADDR)) |=> REG_RDATA == $past(REG_WDATA, 2))
        else $error("setting readback wrong");
    unmapped_zero_a: assert property (CE && !(REG_ADDR inside {[8'h30:8'h32], [8'h5c:8'h61]})
        |=> REG_RDATA == 8'h00) else $error("unmapped read not zero");
    hold_freeze_a: assert property (!CE |=> $stable(REG_RDATA) && $stable(PWM_OUT))
        else $error("outputs moved while frozen");
    reset_full_a: assert property ($rose(RSTN) |-> PWM_OUT == 3'h7 && REG_RDATA == 8'h00)
        else $error("reset outputs wrong");
    full_read_a: assert property (quiet_ff >= SETTLE && CE && REG_ADDR == 8'h30 && bhv0_ff == 3'h3
        |=> REG_RDATA == 8'hff) else $error("full duty readback wrong");
    off_read_a: assert property (quiet_ff >= SETTLE && CE && REG_ADDR == 8'h30 && bhv0_ff == 3'h4
        |=> REG_RDATA == 8'h00) else $error("off duty readback wrong");
    pin_level_a: assert property (quiet_ff >= SETTLE && bhv0_ff inside {3'h3, 3'h4}
        |-> PWM_OUT[0] == ((bhv0_ff == 3'h3) ^ inv0_ff)) else $error("fan 1 pin level wrong");
endmodule : fpd_top_chk
bind fpd_top fpd_top_chk #(.LF_CYC(LF_CYC)) fpd_top_chk_i (.SYS_CLK(SYS_CLK), .RSTN(RSTN), .CE(CE),
    .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RDATA(REG_RDATA), .DC_FAN(DC_FAN),
    .PWM_OUT(PWM_OUT), .TACH_CONT(TACH_CONT));
`default_nettype wire

// File: fpd_fan_model.sv
// Purpose: Fan-side model measuring each pin's last period and active time.
// Assumes: Noninverted pins; a period runs between rising edges.
// Notes: A pin stuck at one level keeps its last figures.
`timescale 1ns/10ps
`default_nettype none
module fpd_fan_model (
    // Clock
    input wire logic clk,
    // Drive pins
    input wire logic [2:0] pwm,
    // Last full period and its active cycles
    output logic [19:0] hi_cnt [3],
    output logic [19:0] per_cnt [3]
);
    logic [19:0] h_ff [3];
    logic [19:0] p_ff [3];
    logic [2:0] last_ff;
    // Count every edge, latch figures at each rising pin edge
    always_ff @(posedge clk) begin
        last_ff <= pwm;
        for (int i = 0; i < 3; i++) begin
            if (pwm[i] && !last_ff[i]) begin
                hi_cnt[i] <= h_ff[i];
                per_cnt[i] <= p_ff[i];
                h_ff[i] <= 20'h1;
                p_ff[i] <= 20'h1;
            end else begin
                h_ff[i] <= h_ff[i] + 20'(pwm[i]);
                p_ff[i] <= p_ff[i] + 20'h1;
            end
        end
    end
endmodule : fpd_fan_model
`default_nettype wire

// File: tb_fan_pwm_drive_and_duty_control.sv
// Purpose: Self-checking bench for the three-fan PWM drive block.
// Assumes: Short low-rate periods by parameter; inputs change on the falling edge.
// Notes: Fixed-seed shift register feeds duties, rates and temperatures.
`timescale 1ns/10ps
`default_nettype none
`include "fpd_consts.svh"
module tb_fan_pwm_drive_and_duty_control;
    import fpd_pkg::*;
    localparam logic [19:0] LFC [0:7] = '{20'h14, 20'h18, 20'h1c, 20'h20, 20'h24, 20'h28, 20'h2c, 20'h30};
    localparam int W = 1000; // Outlasts two of the longest periods
    logic clk, rstn, ce, wr;
    logic [7:0] addr, wdata, rdata, otl, rd, d;
    fpd_trio_t tin, stt, spn, mnd, mxd, rmp;
    logic [2:0] otm, dcf, pwm, tach, hfm, r;
    logic [19:0] hi [3];
    logic [19:0] per [3];
    logic [31:0] lfsr;
    int n_fail, num_checks, c, x;
    int e [3];
    logic [2:0] ac [5] = '{3'h0, 3'h1, 3'h2, 3'h5, 3'h6};
    logic [7:0] md [3] = '{8'h60, 8'h80, 8'h90};
    fpd_top #(.LF_CYC(LFC)) fpd_top_i (.SYS_CLK(clk), .RSTN(rstn), .CE(ce), .REG_ADDR(addr), .REG_WDATA(wdata),
        .REG_WR(wr), .REG_RDATA(rdata), .TEMP_IN(tin), .START_TEMP(stt), .TEMP_SPAN(spn), .OVERTEMP_LIMIT(otl),
        .MIN_DUTY(mnd), .MAX_DUTY(mxd), .RAMP_STEP(rmp), .OT_TO_MAX(otm), .DC_FAN(dcf), .PWM_OUT(pwm),
        .TACH_CONT(tach));
    fpd_fan_model fpd_fan_model_i (.clk(clk), .pwm(pwm), .hi_cnt(hi), .per_cnt(per));
    // 10 MHz clock
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    function automatic logic [31:0] rnd();
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return lfsr;
    endfunction : rnd
    // Automatic duty for one temperature channel
    function automatic int auto_duty(int t, int s, int sp, int mn);
        if (t <= s) return 0;
        if (t - s >= sp) return 255;
        return mn + (255 - mn) * (t - s) / sp;
    endfunction : auto_duty
    task automatic chk(string what, logic [19:0] exp, logic [19:0] got);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic idle(int n);
        repeat (n) @(negedge clk);
    endtask : idle
    // Write strobe lasts one cycle; address held through the next edge
    task automatic wreg(logic [7:0] a, logic [7:0] v);
        @(negedge clk);
        addr = a;
        wdata = v;
        wr = 1'b1;
        @(negedge clk);
        wr = 1'b0;
    endtask : wreg
    task automatic rchk(string what, logic [7:0] a, logic [7:0] exp);
        @(negedge clk);
        addr = a;
        idle(2);
        rd = rdata;
        chk(what, 20'(exp), 20'(rd));
    endtask : rchk
    task automatic give_verdict();
        if (n_fail == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : give_verdict
    // Watchdog against a hang
    initial begin
        repeat (90000) @(posedge clk);
        n_fail++;
        give_verdict();
    end
    initial begin
        lfsr = 32'hc9b3b750;
        n_fail = 0;
        num_checks = 0;
        {rstn, wr, addr, wdata, tin, stt, spn, mnd, mxd, rmp, otm, hfm} = '0;
        ce = 1'b1;
        otl = 8'hff;
        dcf = 3'(rnd());
        idle(20);
        chk("pwm_rst", 20'h7, 20'(pwm));
        rstn = 1'b1;
        for (int i = 0; i < 3; i++) begin
            rchk("cfg", 8'h5c + 8'(i), 8'h82);
            rchk("rate", 8'h5f + 8'(i), 8'h04);
        end
        wreg(8'h30, 8'h55);
        wreg(8'h40, 8'h5a);
        idle(W);
        rchk("duty_off", 8'h30, 8'h00);
        rchk("unmapped", 8'h40, 8'h00);
        // Full, off, inverted off on fan 1
        foreach (md[k]) begin
            wreg(8'h5c, md[k]);
            idle(W);
            rchk("duty_mode", 8'h30, k == 0 ? 8'hff : 8'h00);
            chk("pin", 20'(k != 1), 20'(pwm[0]));
        end
        // Reset again mid-run
        rstn = 1'b0;
        idle(3);
        rstn = 1'b1;
        rchk("cfg_rst", 8'h5c, 8'h82);
        // Manual duty at high rate, each fan in turn twice, random duty and stale rate code
        for (int k = 0; k < 6; k++) begin
            c = k % 3;
            d = 8'(rnd() % 254 + 1);
            r = 3'(rnd());
            hfm[c] = 1'b1;
            wreg(8'h5c + 8'(c), 8'he0);
            wreg(8'h5f + 8'(c), {5'h01, r});
            wreg(8'h30 + 8'(c), d);
            idle(3 * `FPD_HF_CYC + 10);
            rchk("duty_man", 8'h30 + 8'(c), d);
            chk("tach", 20'(dcf | hfm), 20'(tach));
            chk("per_hf", 20'(`FPD_HF_CYC), per[c]);
            chk("hi_hf", 20'((int'(d) * `FPD_HF_CYC + 254) / 255), hi[c]);
        end
        // Every low rate code on fan 2; a mid duty so a short period still shows both edges
        wreg(8'h31, 8'h80);
        for (int k = 0; k < 8; k++) begin
            wreg(8'h60, 8'(k));
            idle(600);
            chk("per_lf", LFC[k], per[1]);
            chk("hi_lf", 20'((128 * int'(LFC[k]) + 254) / 255), hi[1]);
        end
        hfm[1] = 1'b0;
        chk("tach_lf", 20'(dcf | hfm), 20'(tach));
        // Overtemperature in manual mode, both targets
        otl = 8'h50;
        tin[1] = 8'h60;
        mxd[2] = 8'hc0;
        for (int m = 0; m < 2; m++) begin
            otm = 3'(m << 2);
            idle(W);
            rchk("duty_ot", 8'h32, m ? 8'hc0 : 8'hff);
        end
        otl = 8'hff;
        // Automatic codes: at start, at top of span, just above start, random
        foreach (ac[k]) begin
            wreg(8'h5c, {ac[k], 5'h02});
            for (int it = 0; it < 4; it++) begin
                stt = 24'(rnd()) & 24'h7f7f7f;
                spn = 24'(rnd()) & 24'h3f3f3f;
                tin = 24'(rnd());
                mnd[0] = 8'(rnd());
                for (int j = 0; j < 3; j++) begin
                    if (it < 3) tin[j] = stt[j] + (it == 1 ? spn[j] : 8'(it == 2));
                end
                idle(W);
                x = 0;
                for (int j = 0; j < 3; j++) begin
                    e[j] = auto_duty(tin[j], stt[j], spn[j], mnd[0]);
                    if ((ac[k] < 3 && j == ac[k]) || (ac[k] == 5 && j > 0) || ac[k] == 6) x = e[j] > x ? e[j] : x;
                end
                rchk("duty_auto", 8'h30, 8'(x));
            end
        end
        // Ramp limit on fan 1: from zero, two or three steps land in one window, then full
        rmp = '0;
        tin = '0;
        idle(W);
        rmp[0] = 8'h10;
        tin = '1;
        idle(W);
        addr = 8'h30;
        idle(2);
        chk("duty_ramp", 20'h1, 20'(rdata inside {8'h20, 8'h30}));
        idle(16 * `FPD_HF_CYC);
        rchk("duty_ramp_top", 8'h30, 8'hff);
        // Clock enable low freezes the read port
        ce = 1'b0;
        addr = 8'h5c;
        idle(50);
        chk("freeze", 20'(rd), 20'(rdata));
        ce = 1'b1;
        give_verdict();
    end
endmodule : tb_fan_pwm_drive_and_duty_control
`default_nettype wire
